// ---- cfi_cable_model.sv ----
// Purpose: Far-end equipment driving the cable control lines
// Assumes: Levels are requested by the bench
// Notes: Fixed skew keeps line changes off the aclk edge
`timescale 1ns/10ps
module cfi_cable_model (
  // Requested levels
  input wire logic [4:0] want,
  // Cable lines
  output wire logic strobe,
  output wire logic line_b,
  output wire logic line_d,
  output wire logic tx_drv,
  output wire logic rx_rdy
);
  // Skew makes the lines asynchronous to aclk
  assign #3 {rx_rdy, tx_drv, line_d, line_b, strobe} = want;
endmodule

// ---- cfi_intr_ctrl.sv ----
// Contract
// RQ1: Read-write enable register at 0x30, bits 23 to 31 reserved read zero.
// RQ2: Enable bits 0 and 1 gate strobe line rising and falling edges.
// RQ3: Enable bits 2,3,4 gate strobe, line b, line d at one.
// RQ4: Enable bits 5 and 6 gate far transmitter driving and receiver ready.
// RQ5: Enable bit 7 gates transmit message done.
// RQ6: Enable bits 8 to 11 gate tx empty, almost empty, almost full, full.
// RQ7: Enable bits 12 and 13 gate rx not empty and not almost empty.
// RQ8: Enable bits 14 and 15 gate rx almost full and full.
// RQ9: Enable bits 16,17,18 gate rx underflow, rx overflow, tx overflow.
// RQ10: Enable bits 19 and 20 gate rx parity and data errors.
// RQ11: Enable bits 21 and 22 gate receiver busy and transmitter busy.
// RQ12: Status at 0x34, one independent bit per condition, same positions.
// RQ13: Enabled condition latches its status bit until software clears it.
// RQ14: Disabled condition shows its live state in the status bit.
// RQ15: Disabled bits 0 and 1 show an edge only while it is present.
// RQ16: Disabled bits 2 to 6 show the current cable line level.
// RQ17: Data error input is a mid-cell transition, cleared by receiver start.
// RQ18: Parity error input flags received parity fault, cleared by receiver start.
// RQ19: Interrupt request high while any enabled latched status bit is set.
// RQ20: Cable lines pass two flops; edge is change between synced samples.
//
// Purpose: Interrupt enable and status registers behind AXI4-Lite
// Assumes: Error, FIFO and busy conditions come from logic on aclk
// Notes: Status is cleared by writing one to a bit (write one to clear)
`timescale 1ns/10ps
module cfi_intr_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Cable lines, asynchronous to aclk
  input wire logic cable_data_strobe_line,
  input wire logic cable_ctl_line_b,
  input wire logic cable_ctl_line_d,
  input wire logic cable_tx_driving_line,
  input wire logic cable_rx_ready_line,
  // Internal conditions on aclk
  input wire logic tx_message_done,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_almost_empty,
  input wire logic tx_fifo_almost_full,
  input wire logic tx_fifo_full,
  input wire logic rx_fifo_empty,
  input wire logic rx_fifo_almost_empty,
  input wire logic rx_fifo_almost_full,
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_underflow,
  input wire logic rx_fifo_overflow,
  input wire logic tx_fifo_overflow,
  input wire logic rx_parity_error,
  input wire logic rx_data_error,
  input wire logic rx_busy,
  input wire logic tx_busy,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt request
  output logic irq
);
  localparam int unsigned N = cfi_pkg::NUM_COND;

  cfi_pkg::cfi_state_s st_ff;
  cfi_pkg::cfi_state_s nxt_st;
  logic [N-1:0] cond;
  logic [N-1:0] status;
  logic [N-1:0] clr_mask;
  logic [31:0] wmask;
  logic strobe_s;
  logic wr_fire;

  ////////////////////////////////////////////////////////////////////////
  // RQ20: synced cable lines
  assign strobe_s = st_ff.sync2[0];

  // RQ2: edge conditions
  // RQ3: RQ4: line levels
  // RQ5: RQ6: RQ7: RQ8: RQ9: RQ10: RQ11: condition bit map
  // RQ17: RQ18: errors arrive already formed by the receiver
  assign cond = {tx_busy, rx_busy, rx_data_error, rx_parity_error,
                 tx_fifo_overflow, rx_fifo_overflow, rx_fifo_underflow,
                 rx_fifo_full, rx_fifo_almost_full, ~rx_fifo_almost_empty, ~rx_fifo_empty,
                 tx_fifo_full, tx_fifo_almost_full, tx_fifo_almost_empty, tx_fifo_empty,
                 tx_message_done, st_ff.sync2[4:1], strobe_s,
                 ~strobe_s & st_ff.strobe_prev, strobe_s & ~st_ff.strobe_prev};

  // RQ12: RQ14: RQ15: RQ16: per-bit choice of latched or live view
  // Disabled edge bits therefore show a one-cycle pulse only
  assign status = (st_ff.enable & st_ff.latched) | (~st_ff.enable & st_ff.live);

  // RQ19: enabled latched bits drive the request
  assign irq = |(st_ff.enable & st_ff.latched);

  assign wmask = {{8{st_ff.wstrb[3]}}, {8{st_ff.wstrb[2]}}, {8{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}};
  assign wr_fire = st_ff.awvalid_seen && st_ff.wvalid_seen && !st_ff.bvalid;
  assign clr_mask = (wr_fire && st_ff.awaddr == cfi_pkg::ADDR_STATUS) ?
                    (st_ff.wdata[N-1:0] & wmask[N-1:0]) : '0;

  assign s_axi_awready = !st_ff.awvalid_seen && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.wvalid_seen && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = {cable_rx_ready_line, cable_tx_driving_line, cable_ctl_line_d,
                    cable_ctl_line_b, cable_data_strobe_line};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.strobe_prev = strobe_s;
    nxt_st.live = cond;
    // RQ13: set wins over a clear in the same cycle
    nxt_st.latched = (st_ff.latched & ~clr_mask) | (st_ff.live & st_ff.enable);
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.awvalid_seen = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wvalid_seen = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_st.awvalid_seen = 1'b0;
      nxt_st.wvalid_seen = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = cfi_pkg::RESP_OKAY;
      // RQ1: enable register write, reserved bits dropped
      if (st_ff.awaddr == cfi_pkg::ADDR_ENABLE) begin
        nxt_st.enable = (st_ff.enable & ~wmask[N-1:0]) | (st_ff.wdata[N-1:0] & wmask[N-1:0]);
      end else if (st_ff.awaddr != cfi_pkg::ADDR_STATUS) begin
        nxt_st.bresp = cfi_pkg::RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = cfi_pkg::RESP_OKAY;
      nxt_st.rdata = '0;
      if (s_axi_araddr == cfi_pkg::ADDR_ENABLE) begin
        nxt_st.rdata[N-1:0] = st_ff.enable;
      end else if (s_axi_araddr == cfi_pkg::ADDR_STATUS) begin
        nxt_st.rdata[N-1:0] = status;
      end else begin
        nxt_st.rresp = cfi_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.enable <= cfi_pkg::ENABLE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // RQ13: latch holds
  latch_hold_a: assert property (st_ff.latched[7] && !clr_mask[7] |=> st_ff.latched[7]) // RQ13
    else $error("latched status bit dropped without clear");

  // RQ13: latch sets
  latch_set_a: assert property (st_ff.enable[8] && st_ff.live[8] |=> st_ff.latched[8]) // RQ13
    else $error("enabled condition not latched");

  // RQ13: set beats clear
  set_wins_a: assert property (st_ff.enable[9] && st_ff.live[9] && clr_mask[9] |=> st_ff.latched[9]) // RQ13
    else $error("clear beat a new event");

  // RQ14: live view
  live_view_a: assert property (!st_ff.enable[3] |-> status[3] == st_ff.live[3]) // RQ14
    else $error("disabled status bit not live");

  // RQ16: disabled line level
  line_view_a: assert property (!st_ff.enable[4] |-> status[4] == $past(st_ff.sync2[2])) // RQ16
    else $error("disabled line bit not current level");

  // RQ19: request level
  irq_any_a: assert property (irq == |(st_ff.enable & st_ff.latched)) // RQ19
    else $error("interrupt request mismatch");

  // RQ15: rising edge
  rise_edge_a: assert property ($rose(strobe_s) |=> st_ff.live[cfi_pkg::BIT_RISE]) // RQ15
    else $error("rising edge not seen");

  // RQ15: falling edge
  fall_edge_a: assert property ($fell(strobe_s) |=> st_ff.live[cfi_pkg::BIT_FALL]) // RQ15
    else $error("falling edge not seen");

  // RQ15: edge is a pulse
  edge_pulse_a: assert property (st_ff.live[cfi_pkg::BIT_RISE] |=> !st_ff.live[cfi_pkg::BIT_RISE]) // RQ15
    else $error("rise indication lasted too long");

  // RQ2: rising edge gated
  rise_gate_a: assert property (st_ff.enable[0] && st_ff.live[0] |=> st_ff.latched[0]) // RQ2
    else $error("enabled rising edge not latched");

  // RQ2: falling edge gated
  fall_gate_a: assert property (st_ff.enable[1] && st_ff.live[1] |=> st_ff.latched[1]) // RQ2
    else $error("enabled falling edge not latched");

  // RQ20: two-stage sync
  sync_delay_a: assert property (st_ff.sync2[2] == $past(cable_ctl_line_d, 2)) // RQ20
    else $error("line d not two-stage synced");

  // RQ3: line level map
  level_map_a: assert property (st_ff.live[6:2] == $past(st_ff.sync2)) // RQ3
    else $error("cable line levels misplaced");

  // RQ5: done bit map
  done_map_a: assert property (st_ff.live[7] == $past(tx_message_done)) // RQ5
    else $error("transmit done misplaced");

  // RQ6: tx flag map
  tx_map_a: assert property (st_ff.live[11:8] ==
    $past({tx_fifo_full, tx_fifo_almost_full, tx_fifo_almost_empty, tx_fifo_empty})) // RQ6
    else $error("tx fifo flags misplaced");

  // RQ7: inverted rx empty flag
  rx_invert_a: assert property (st_ff.live[12] == !$past(rx_fifo_empty)) // RQ7
    else $error("rx not empty polarity wrong");

  // RQ7: inverted almost empty
  rx_alm_inv_a: assert property (st_ff.live[13] == !$past(rx_fifo_almost_empty)) // RQ7
    else $error("rx not almost empty polarity wrong");

  // RQ8: rx full map
  rx_full_map_a: assert property (st_ff.live[15:14] == $past({rx_fifo_full, rx_fifo_almost_full})) // RQ8
    else $error("rx fifo full flags misplaced");

  // RQ9: flow error map
  flow_map_a: assert property (st_ff.live[18:16] ==
    $past({tx_fifo_overflow, rx_fifo_overflow, rx_fifo_underflow})) // RQ9
    else $error("fifo flow errors misplaced");

  // RQ10: receive error map
  err_map_a: assert property (st_ff.live[20:19] == $past({rx_data_error, rx_parity_error})) // RQ10
    else $error("receive errors misplaced");

  // RQ11: busy map
  busy_map_a: assert property (st_ff.live[22:21] == $past({tx_busy, rx_busy})) // RQ11
    else $error("busy flags misplaced");

  // RQ1: reserved bits
  reserved_rd_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rdata[31:N] == '0) // RQ1
    else $error("reserved bits read nonzero");

  // RQ1: enable write
  en_write_a: assert property (wr_fire && st_ff.awaddr == cfi_pkg::ADDR_ENABLE && st_ff.wstrb[0]
    |=> st_ff.enable[7:0] == $past(st_ff.wdata[7:0])) // RQ1
    else $error("enable write lost");

  // RQ12: write answered
  wr_resp_a: assert property (wr_fire |=> s_axi_bvalid) // RQ12
    else $error("no write response");

  // RQ12: other bits untouched
  bit_indep_a: assert property (st_ff.latched[20] && !clr_mask[20] |=> st_ff.latched[20]) // RQ12
    else $error("clear of one bit disturbed another");

  // RQ12: status read back
  status_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == cfi_pkg::ADDR_STATUS
    |=> s_axi_rdata[N-1:0] == $past(status)) // RQ12
    else $error("status read differs from status");

  irq_cov_c: cover property (!irq ##1 irq);
  clear_cov_c: cover property (irq ##[1:20] !irq);
  read_status_c: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == cfi_pkg::ADDR_STATUS);
  edge_latch_c: cover property (st_ff.enable[0] && st_ff.live[0]);
  rd_err_c: cover property (s_axi_rvalid && s_axi_rresp == cfi_pkg::RESP_SLVERR);
endmodule

// ---- cfi_pkg.sv ----
// Purpose: Shared constants and types for the cable FIFO interrupt logic
// Assumes: 32-bit AXI4-Lite register access, byte addresses as printed
// Notes: Condition bit positions match enable and status bit positions
package cfi_pkg;
  localparam int unsigned NUM_COND = 23;
  localparam logic [7:0] ADDR_ENABLE = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [22:0] ENABLE_RESET = 23'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned BIT_RISE = 0;
  localparam int unsigned BIT_FALL = 1;

  // Raw condition inputs from the cable and the FIFO/transceiver logic
  typedef struct packed {
    logic tx_busy;
    logic rx_busy;
    logic rx_data_error;
    logic rx_parity_error;
    logic tx_fifo_overflow;
    logic rx_fifo_overflow;
    logic rx_fifo_underflow;
    logic rx_fifo_full;
    logic rx_fifo_almost_full;
    logic rx_fifo_not_almost_empty;
    logic rx_fifo_not_empty;
    logic tx_fifo_full;
    logic tx_fifo_almost_full;
    logic tx_fifo_almost_empty;
    logic tx_fifo_empty;
    logic tx_message_done;
    logic cable_rx_ready_line;
    logic cable_tx_driving_line;
    logic cable_ctl_line_d;
    logic cable_ctl_line_b;
    logic cable_data_strobe_line;
  } cfi_cond_s;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic strobe_prev;
    logic [NUM_COND-1:0] enable;
    logic [NUM_COND-1:0] latched;
    logic [NUM_COND-1:0] live;
    logic awvalid_seen;
    logic [7:0] awaddr;
    logic wvalid_seen;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cfi_state_s;
endpackage

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the interrupt enable and status logic
// Assumes: Every bus answer comes within 50 cycles
// Notes: Cable levels pass through the far-end model
`timescale 1ns/10ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] cab = 5'h00;
  logic [15:0] ic = 16'h0060;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, e, x;
  wire logic [4:0] cl;
  int mismatches = 0;
  int check_count = 0;
  always #5 aclk = ~aclk;
  cfi_cable_model i_cfi_cable_model (.want(cab), .strobe(cl[0]), .line_b(cl[1]), .line_d(cl[2]),
    .tx_drv(cl[3]), .rx_rdy(cl[4]));
  cfi_intr_ctrl i_cfi_intr_ctrl (.aclk, .aresetn, .cable_data_strobe_line(cl[0]), .cable_ctl_line_b(cl[1]),
    .cable_ctl_line_d(cl[2]), .cable_tx_driving_line(cl[3]), .cable_rx_ready_line(cl[4]),
    .tx_message_done(ic[0]), .tx_fifo_empty(ic[1]), .tx_fifo_almost_empty(ic[2]), .tx_fifo_almost_full(ic[3]),
    .tx_fifo_full(ic[4]), .rx_fifo_empty(ic[5]), .rx_fifo_almost_empty(ic[6]), .rx_fifo_almost_full(ic[7]),
    .rx_fifo_full(ic[8]), .rx_fifo_underflow(ic[9]), .rx_fifo_overflow(ic[10]), .tx_fifo_overflow(ic[11]),
    .rx_parity_error(ic[12]), .rx_data_error(ic[13]), .rx_busy(ic[14]), .tx_busy(ic[15]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  ////////////////////////////////////////////////////////////////////////////
  // Rx empty flags are inverted into bits 12 and 13
  function automatic logic [31:0] live(input logic [4:0] c, input logic [15:0] i);
    return {9'h0, i[15:7], ~i[6:5], i[4:0], c, 2'b00};
  endfunction
  task automatic final_report();
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'he2c3));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cfi_pkg::ADDR_ENABLE);
    chk("enable_rst", 32'h0, d);
    rd(8'h38);
    chk("unmapped", {30'h0, cfi_pkg::RESP_SLVERR}, {30'h0, r});
    repeat (4) begin
      e = $urandom;
      wr(cfi_pkg::ADDR_ENABLE, e);
      rd(cfi_pkg::ADDR_ENABLE);
      chk("enable", e & 32'h007fffff, d);
    end
    wr(cfi_pkg::ADDR_ENABLE, 32'h0);
    repeat (6) begin
      ic <= 16'($urandom);
      cab <= 5'($urandom);
      repeat (6) @(posedge aclk);
      rd(cfi_pkg::ADDR_STATUS);
      chk("live", live(cab, ic), d);
    end
    ic <= 16'h0060;
    cab <= 5'h00;
    wr(cfi_pkg::ADDR_ENABLE, 32'h007fff80);
    wr(cfi_pkg::ADDR_STATUS, 32'hffffffff);
    repeat (4) begin
      e = $urandom;
      x = live(5'h00, e[15:0]) & 32'h007fff80;
      ic <= e[15:0];
      repeat (2) @(posedge aclk);
      ic <= 16'h0060;
      repeat (6) @(posedge aclk);
      rd(cfi_pkg::ADDR_STATUS);
      chk("latched", x, d);
      chk("irq_set", {31'h0, |x}, {31'h0, irq});
      wr(cfi_pkg::ADDR_STATUS, x);
      rd(cfi_pkg::ADDR_STATUS);
      chk("cleared", 32'h0, d);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    wr(cfi_pkg::ADDR_ENABLE, 32'h3);
    cab <= 5'h01;
    repeat (6) @(posedge aclk);
    rd(cfi_pkg::ADDR_STATUS);
    chk("rise", 32'h5, d);
    cab <= 5'h00;
    repeat (6) @(posedge aclk);
    rd(cfi_pkg::ADDR_STATUS);
    chk("fall", 32'h3, d);
    wr(cfi_pkg::ADDR_STATUS, 32'h3);
    rd(cfi_pkg::ADDR_STATUS);
    chk("edge_clr", 32'h0, d);
    final_report();
  end
endmodule
